// [hdl/dcr_defs.svh]
// Overview of operation
// (RULE_01) Capture inputs on rising clock edge
// (RULE_02) Re-drive word or route to control access
// (RULE_03) 28-bit or 26-bit plus 4-bit register
// (RULE_04) Strap high: two selects, A and B copies
// (RULE_05) Strap low: four selects, one-to-one
// (RULE_06) Parity checked against input one cycle later
// (RULE_07) Mismatch pulls error output low
// (RULE_08) Enables, terminations, selects excluded from parity
// (RULE_09) Parity checked only on selected cycles
// (RULE_10) Host keeps termination on when mirrored
// (RULE_11) Match releases error output
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH
`define DCR_ADDR_W 16
`define DCR_CMD_W 6
`define DCR_CS_W 4
`define DCR_CKE_W 2
`define DCR_ODT_W 2
`define DCR_CS_IDLE 4'hF
`define DCR_CS_PAIR_IDLE 2'h3
`endif

// [hdl/dcr_pkg.sv]
package dcr_pkg;
  `include "dcr_defs.svh"
  // Command/address word from the host
  typedef struct packed {
    logic [`DCR_ADDR_W-1:0] addr;
    logic [`DCR_CMD_W-1:0] cmd;
  } dcr_ca_t;
  // Control nets, kept out of parity
  typedef struct packed {
    logic [`DCR_CS_W-1:0] chip_select_in_n;
    logic [`DCR_CKE_W-1:0] clock_enable_in;
    logic [`DCR_ODT_W-1:0] on_die_term_in;
  } dcr_ctl_t;
  typedef enum logic {DCR_PAR_IDLE, DCR_PAR_WAIT} dcr_par_state_t;
endpackage

// [hdl/dcr_register.sv]
`timescale 1ns/1ps
module dcr_register
  import dcr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire dcr_ca_t i_ca,
  input wire dcr_ctl_t i_ctl,
  input wire logic i_quad_select_enable_strap,
  input wire logic i_parity_input,
  input wire logic i_ctrl_access,
  output dcr_ca_t o_ca_a,
  output dcr_ca_t o_ca_b,
  output logic [`DCR_CKE_W-1:0] o_clock_enable_a,
  output logic [`DCR_CKE_W-1:0] o_clock_enable_b,
  output logic [`DCR_ODT_W-1:0] o_on_die_term_a,
  output logic [`DCR_ODT_W-1:0] o_on_die_term_b,
  output logic [1:0] o_chip_select_out_a_n,
  output logic [1:0] o_chip_select_out_b_n,
  output logic [`DCR_CS_W-1:0] o_chip_select_out_quad_n,
  output dcr_ca_t o_ctrl_word,
  output logic o_ctrl_valid,
  output logic o_parity_error_output_out,
  output logic o_parity_error_output_oe
);
  `include "dcr_defs.svh"

  // Even parity of command and address bits only
  function automatic logic ca_parity(input dcr_ca_t w);
    ca_parity = ^w; // RULE_08
  endfunction

  // Any chip select asserted; selects are active low
  function automatic logic any_select(input dcr_ctl_t c);
    any_select = ~&c.chip_select_in_n;
  endfunction

  // Fan-out copies toward the memory devices
  dcr_ca_t ca_a;
  dcr_ca_t ca_b;
  dcr_ca_t next_ca_a;
  dcr_ca_t next_ca_b;
  // Word and strobe of a control access
  dcr_ca_t ctrl_word;
  dcr_ca_t next_ctrl_word;
  logic ctrl_valid;
  logic next_ctrl_valid;
  // Control net copies, kept out of parity
  logic [`DCR_CKE_W-1:0] cke_a;
  logic [`DCR_CKE_W-1:0] cke_b;
  logic [`DCR_CKE_W-1:0] next_cke_a;
  logic [`DCR_CKE_W-1:0] next_cke_b;
  logic [`DCR_ODT_W-1:0] odt_a;
  logic [`DCR_ODT_W-1:0] odt_b;
  logic [`DCR_ODT_W-1:0] next_odt_a;
  logic [`DCR_ODT_W-1:0] next_odt_b;
  // Chip select copies for both strap modes
  logic [1:0] csa;
  logic [1:0] csb;
  logic [1:0] next_csa;
  logic [1:0] next_csb;
  logic [`DCR_CS_W-1:0] csq;
  logic [`DCR_CS_W-1:0] next_csq;
  // Parity tracking and error pin drive
  dcr_ca_t held;
  dcr_ca_t next_held;
  dcr_par_state_t st;
  dcr_par_state_t next_st;
  logic err_oe;
  logic next_err_oe;
  logic err_out;
  logic next_err_out;
  logic selected;

  // Word takes part in checking only when a select is low
  assign selected = any_select(i_ctl); // RULE_09

  ////////////////////////////////////////////////////////////////////
  // Output fan-out next values
  always_comb begin
    // Data copies hold while a word goes to control access
    next_ca_a = ca_a;
    next_ca_b = ca_b;
    next_ctrl_word = ctrl_word;
    next_ctrl_valid = 1'b0;
    next_cke_a = i_ctl.clock_enable_in; // RULE_03
    next_cke_b = i_ctl.clock_enable_in;
    next_odt_a = i_ctl.on_die_term_in;
    next_odt_b = i_ctl.on_die_term_in;
    if (i_ctrl_access) begin
      next_ctrl_word = i_ca; // RULE_02
      next_ctrl_valid = selected;
    end else begin
      next_ca_a = i_ca; // RULE_02
      next_ca_b = i_ca; // RULE_03
    end
  end

  // Fan-out registers, loaded on the rising clock edge
  always_ff @(posedge i_core_clk or posedge i_reset) begin // RULE_01
    if (i_reset) begin
      ca_a <= '0;
      ca_b <= '0;
      ctrl_word <= '0;
      ctrl_valid <= 1'b0;
      cke_a <= '0;
      cke_b <= '0;
      odt_a <= '0;
      odt_b <= '0;
    end else begin
      ca_a <= next_ca_a;
      ca_b <= next_ca_b;
      ctrl_word <= next_ctrl_word;
      ctrl_valid <= next_ctrl_valid;
      cke_a <= next_cke_a;
      cke_b <= next_cke_b;
      odt_a <= next_odt_a;
      odt_b <= next_odt_b;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Chip select routing by strap mode
  always_comb begin
    // Copies unused in the current mode stay deasserted
    next_csa = `DCR_CS_PAIR_IDLE;
    next_csb = `DCR_CS_PAIR_IDLE;
    next_csq = `DCR_CS_IDLE;
    if (i_quad_select_enable_strap) begin
      next_csa = i_ctl.chip_select_in_n[1:0]; // RULE_04
      next_csb = i_ctl.chip_select_in_n[1:0]; // RULE_04
    end else begin
      next_csq = i_ctl.chip_select_in_n; // RULE_05
    end
  end

  // Chip select registers
  always_ff @(posedge i_core_clk or posedge i_reset) begin // RULE_01
    if (i_reset) begin
      csa <= `DCR_CS_PAIR_IDLE;
      csb <= `DCR_CS_PAIR_IDLE;
      csq <= `DCR_CS_IDLE;
    end else begin
      csa <= next_csa;
      csb <= next_csb;
      csq <= next_csq;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Parity check against the late parity bit
  always_comb begin
    next_held = held;
    next_err_oe = err_oe;
    next_st = DCR_PAR_IDLE;
    case (st)
      DCR_PAR_IDLE: begin
        next_err_oe = err_oe; // RULE_09
      end
      DCR_PAR_WAIT: begin
        next_err_oe = ca_parity(held) != i_parity_input; // RULE_06 RULE_07 RULE_11
      end
      default: next_st = DCR_PAR_IDLE;
    endcase
    // A selected word is held until its parity bit arrives
    if (selected) begin // RULE_09
      next_held = i_ca;
      next_st = DCR_PAR_WAIT;
    end
  end

  // Parity state registers
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      held <= '0;
      err_oe <= 1'b0;
      st <= DCR_PAR_IDLE;
    end else begin
      held <= next_held;
      err_oe <= next_err_oe;
      st <= next_st;
    end
  end

  // Error pin level: the open-drain pin only ever pulls low
  always_comb begin
    next_err_out = 1'h0; // RULE_07
  end

  // Error pin level register
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      err_out <= 1'h0;
    end else begin
      err_out <= next_err_out;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output wiring: every pin comes straight from a flop
  // Data copies and control access
  assign o_ca_a = ca_a;
  assign o_ca_b = ca_b;
  assign o_ctrl_word = ctrl_word;
  assign o_ctrl_valid = ctrl_valid;

  // Control net copies
  assign o_clock_enable_a = cke_a;
  assign o_clock_enable_b = cke_b;
  assign o_on_die_term_a = odt_a;
  assign o_on_die_term_b = odt_b;

  // Chip select copies
  assign o_chip_select_out_a_n = csa;
  assign o_chip_select_out_b_n = csb;
  assign o_chip_select_out_quad_n = csq;

  // Open-drain error pin: enable high pulls the pin low
  assign o_parity_error_output_out = err_out;
  assign o_parity_error_output_oe = err_oe;
endmodule

// [tb/dcr_register_properties.sv]
`timescale 1ns/1ps
module dcr_chk import dcr_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_quad_select_enable_strap,
  input wire logic i_parity_input,
  input wire logic i_ctrl_access,
  input wire logic o_ctrl_valid,
  input wire logic o_parity_error_output_oe,
  input wire dcr_ca_t i_ca,
  input wire dcr_ca_t o_ca_a,
  input wire dcr_ca_t o_ca_b,
  input wire dcr_ctl_t i_ctl,
  input wire logic [1:0] o_chip_select_out_a_n,
  input wire logic [1:0] o_chip_select_out_b_n,
  input wire logic [3:0] o_chip_select_out_quad_n
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // Select, strap and error enable
  wire s = ~&i_ctl.chip_select_in_n;
  wire q = i_quad_select_enable_strap;
  wire e = o_parity_error_output_oe;
  AST_CA: assert property (!i_ctrl_access |=> o_ca_a == $past(i_ca)) else $error("ca");
  AST_DUP: assert property (o_ca_a == o_ca_b) else $error("dup");
  AST_HOLD: assert property (i_ctrl_access |=> $stable(o_ca_a)) else $error("hold");
  AST_ACC: assert property (i_ctrl_access && s |=> o_ctrl_valid) else $error("acc");
  AST_TWO: assert property (q |=>
    o_chip_select_out_a_n == $past(i_ctl.chip_select_in_n[1:0])) else $error("two");
  AST_FOUR: assert property (!q |=>
    o_chip_select_out_quad_n == $past(i_ctl.chip_select_in_n)) else $error("four");
  AST_BCOPY: assert property (
    o_chip_select_out_b_n == o_chip_select_out_a_n) else $error("bcopy");
  AST_QIDLE: assert property (q |=>
    o_chip_select_out_quad_n == 4'hF) else $error("qidle");
  AST_AIDLE: assert property (!q |=>
    o_chip_select_out_a_n == 2'h3) else $error("aidle");
  AST_PAR: assert property (s |=> ##1
    e == (^$past(i_ca, 2) ^ $past(i_parity_input))) else $error("par");
  AST_GATE: assert property (!s |=> ##1 $stable(e)) else $error("gate");
  C_ERR: cover property (s ##2 e);
  C_QUAD: cover property (!q && s);
  C_ACC: cover property (o_ctrl_valid);
endmodule
bind dcr_register dcr_chk dcr_chk_inst (.*);

// [tb/dcr_host.sv]
`timescale 1ns/1ps
module dcr_host import dcr_pkg::*; (
  input wire logic i_clk,
  input wire dcr_ca_t i_ca,
  input wire logic i_bad,
  output logic o_par = 1'b0
);
  // Even parity of the word, one cycle late
  always @(posedge i_clk) o_par <= #1 ^i_ca ^ i_bad;
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import dcr_pkg::*;
  logic clk = 0, rst = 1, st = 1, acc = 0, bad = 0, par, oe, ee = 0, pb, ps = 0, cv, eo;
  logic [3:0] qn;
  logic [1:0] cea, ceb, oda, odb, csa, csb;
  dcr_ca_t ca = '0, oa, ob, ec = '0, cw, ew = '0;
  dcr_ctl_t ctl = '1;
  int bad_count = 0, total_checks = 0;
  always #20 clk = ~clk;
  dcr_host dcr_host_inst (.i_clk(clk), .i_ca(ca), .i_bad(bad), .o_par(par));
  dcr_register dcr_register_inst (.i_core_clk(clk), .i_reset(rst), .i_ca(ca), .i_ctl(ctl),
    .i_quad_select_enable_strap(st), .i_parity_input(par), .i_ctrl_access(acc),
    .o_ca_a(oa), .o_ca_b(ob), .o_clock_enable_a(cea), .o_clock_enable_b(ceb),
    .o_on_die_term_a(oda), .o_on_die_term_b(odb), .o_chip_select_out_a_n(csa),
    .o_chip_select_out_b_n(csb), .o_chip_select_out_quad_n(qn), .o_ctrl_word(cw),
    .o_ctrl_valid(cv), .o_parity_error_output_out(eo), .o_parity_error_output_oe(oe));
  task automatic chk(logic [21:0] v, x);
    total_checks++;
    if (v !== x) begin
      bad_count++;
      $display("wrong value %0t %h %h", $time, v, x);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [3:0] eq(logic s, logic [3:0] c);
    return s ? 4'hF : c;
  endfunction
  // Expected A/B chip select copy for a strap level
  function automatic logic [1:0] ea(logic s, logic [3:0] c);
    return s ? c[1:0] : 2'h3;
  endfunction
  initial begin
    #100000;
    bad_count++;
    results;
  end
  // Random words, first six selected with alternating bad parity
  initial begin
    void'($urandom(69));
    repeat (2) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 600; i++) begin
      @(posedge clk);
      #1;
      if (!acc) ec = ca;
      if (ps) ee = pb;
      chk(oa, ec);
      chk(ob, ec);
      chk(qn, eq(st, ctl.chip_select_in_n));
      chk(oe, ee);
      if (acc) ew = ca;
      chk(cw, ew);
      chk(cv, acc && ~&ctl.chip_select_in_n);
      chk(csa, ea(st, ctl.chip_select_in_n));
      chk(csb, ea(st, ctl.chip_select_in_n));
      chk({cea, ceb}, {2{ctl.clock_enable_in}});
      chk({oda, odb}, {2{ctl.on_die_term_in}});
      chk(eo, 1'h0);
      ps = ~&ctl.chip_select_in_n;
      pb = bad;
      ca = 22'($urandom);
      ctl = 8'($urandom);
      st = 1'($urandom);
      acc = $urandom % 4 == 0;
      bad = 1'($urandom);
      if (i < 6) begin
        ctl.chip_select_in_n = 4'h0;
        bad = i[0];
      end
    end
    results;
  end
endmodule
